// ===== shared/aebp_pkg.sv
/*
 * Constants, register map and carrier types of the asynchronous external
 * bus port. Assumes a 100 MHz core clock shared by all users of the package.
 */
package aebp_pkg;
  localparam int CLK_NS = 10;
  // Wishbone register byte offsets
  localparam logic [7:0] REG_PHASE  = 8'h00;
  localparam logic [7:0] REG_MADDR  = 8'h04;
  localparam logic [7:0] REG_MDATA  = 8'h08;
  localparam logic [7:0] REG_MCMD   = 8'h0C;
  localparam logic [7:0] REG_MRDATA = 8'h10;
  localparam logic [7:0] REG_SCFG   = 8'h14;
  localparam logic [7:0] REG_SSTAT  = 8'h18;
  // Field positions
  localparam int PH_SETUP = 0;
  localparam int PH_DATA  = 8;
  localparam int PH_HOLD  = 16;
  localparam int PH_RECOV = 24;
  localparam int PH_W     = 7;
  localparam int CMD_GO   = 0;
  localparam int CMD_WR   = 1;
  localparam int CMD_WORD = 2;
  localparam int CMD_DBL  = 3;
  localparam int SCFG_DLY = 0;
  localparam int SCFG_CON = 2;
  localparam logic [31:0] PHASE_RST = 32'h0101_0101;
  localparam logic [2:0]  SCFG_RST  = 3'h0;
  // Timing in ns and derived cycle counts
  localparam int WAIT_REL_MIN_NS = 10;
  localparam int SWAIT_START_NS  = 36;
  localparam int SWAIT_MAX_NS    = 90;
  localparam int RD_FREE_NS      = 59;
  localparam int RD_CONT_NS      = 116;
  localparam int WE_STEP_NS      = 5;
  localparam int WDSU_NS         = 8;
  localparam int WAIT_REL_CYC  = (WAIT_REL_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int SWAIT_ST_CYC  = SWAIT_START_NS / CLK_NS;
  localparam int SWAIT_MAX_CYC = SWAIT_MAX_NS / CLK_NS;
  localparam int RD_FREE_CYC   = RD_FREE_NS / CLK_NS;
  localparam int RD_CONT_CYC   = RD_CONT_NS / CLK_NS;

  typedef enum logic [2:0] {
    M_IDLE  = 3'b000,
    M_SETUP = 3'b001,
    M_DATA  = 3'b011,
    M_HOLD  = 3'b010,
    M_RECOV = 3'b110
  } aebp_mstate_type;

  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_DLY  = 2'b01,
    S_REQ  = 2'b11,
    S_DONE = 2'b10
  } aebp_sstate_type;

  typedef struct packed {
    logic [23:0] addr;
    logic        wr;
    logic        word;
    logic        dbl;
  } aebp_mcmd_type;

  typedef struct packed {
    logic        req;
    logic        we;
    logic [15:0] addr;
    logic [1:0]  be;
    logic [15:0] wdata;
  } aebp_ireq_type;
endpackage : aebp_pkg

// ===== rtl/aebp_port.sv
/* Asynchronous external bus port: phased master transfers to peripherals,
   a slave engine for an external processor, registers over Wishbone.
   Assumes all pin inputs synchronous to clk_i (external synchronisers). */
// Operation
// - Wider transfers split into consecutive bus-width transfers.
// - Master setup, data, hold, recover phases each last 1 to 127 cycles.
// - Wait holds data phase; release moves to hold within 10 to 20 ns.
// - Software sizes unwaited read data phase for strobe, access, setup.
// - Slave write delay code 0..3 adds 0..15 ns before data capture.
// - Slave read data valid within 59 ns, or 116 ns with contention.
// - Slave wait rises within 36 ns plus delay; lasts 5 to 90 ns.
`timescale 1ns/1ps
module aebp_port
  import aebp_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic      [23:0] m_addr_o,
  output logic      [15:0] m_data_o,
  output logic             m_data_oe_o,
  input  wire logic [15:0] m_data_i,
  output logic             m_cs_n_o,
  output logic             master_read_strobe_n_o,
  output logic             m_write_strobe_n_o,
  output logic      [1:0]  m_lane_n_o,
  input  wire logic        master_wait_in_i,
  input  wire logic        s_cs_n_i,
  input  wire logic        s_read_n_i,
  input  wire logic        s_write_n_i,
  input  wire logic [15:0] s_addr_i,
  input  wire logic [1:0]  s_lane_n_i,
  input  wire logic [15:0] s_data_i,
  output logic      [15:0] s_data_o,
  output logic             s_data_oe_o,
  output logic             slave_wait_out_o,
  output aebp_ireq_type    int_req_o,
  input  wire logic [15:0] int_rdata_i,
  input  wire logic        int_ack_i
);

  function automatic logic [6:0] plen(input logic [6:0] x);
    plen = (x == 7'h00) ? 7'h01 : x;
  endfunction : plen
  // Cycles until write data is guaranteed, rounded up
  function automatic logic [3:0] wdly(input logic [1:0] code);
    wdly = 4'((WDSU_NS + WE_STEP_NS * int'(code) + CLK_NS - 1) / CLK_NS);
  endfunction : wdly
  logic [31:0]     phase_reg;
  logic [23:0]     maddr;
  logic [31:0]     mdata;
  logic [31:0]     mrdata;
  logic [2:0]      scfg;
  aebp_mcmd_type   mcmd;
  aebp_mstate_type mst;
  logic [6:0]      mcnt;
  logic            part;
  aebp_sstate_type sst;
  logic [3:0]      scnt;
  logic [3:0]      swcnt;
  logic [15:0]     srdata;

  // Wishbone slave: one-cycle registered ack
  wire wb_req  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wb_wr   = wb_req & wb_we_i & ce_i;
  wire m_busy  = (mst != M_IDLE);
  wire go_cmd  = wb_wr & (wb_adr_i == REG_MCMD) & wb_sel_i[0]
               & wb_dat_i[CMD_GO] & ~m_busy;
  wire [6:0] len_setup = plen(phase_reg[PH_SETUP +: PH_W]);
  wire [6:0] len_data  = plen(phase_reg[PH_DATA  +: PH_W]);
  wire [6:0] len_hold  = plen(phase_reg[PH_HOLD  +: PH_W]);
  wire [6:0] len_recov = plen(phase_reg[PH_RECOV +: PH_W]);

  logic [31:0] next_rd;
  always_comb begin
    case (wb_adr_i)
      REG_PHASE:  next_rd = phase_reg;
      REG_MADDR:  next_rd = {8'h00, maddr};
      REG_MDATA:  next_rd = mdata;
      REG_MCMD:   next_rd = {31'h0000_0000, m_busy};
      REG_MRDATA: next_rd = mrdata;
      REG_SCFG:   next_rd = {29'h0000_0000, scfg};
      REG_SSTAT:  next_rd = {26'h000_0000, swcnt, slave_wait_out_o,
                             (sst != S_IDLE)};
      default:    next_rd = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else if (ce_i) begin
      wb_ack_o <= wb_req;
      wb_dat_o <= wb_req ? next_rd : 32'h0000_0000;
    end
  end

  // Byte-lane aware register writes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase_reg <= PHASE_RST;
      maddr     <= 24'h00_0000;
      mdata     <= 32'h0000_0000;
      scfg      <= SCFG_RST;
    end else if (wb_wr) begin
      for (int b = 0; b < 4; b++) begin
        if (wb_sel_i[b] && wb_adr_i == REG_PHASE)
          phase_reg[b*8 +: 8] <= wb_dat_i[b*8 +: 8];
        if (wb_sel_i[b] && wb_adr_i == REG_MDATA)
          mdata[b*8 +: 8] <= wb_dat_i[b*8 +: 8];
        if (wb_sel_i[b] && b < 3 && wb_adr_i == REG_MADDR)
          maddr[b*8 +: 8] <= wb_dat_i[b*8 +: 8];
      end
      if (wb_sel_i[0] && wb_adr_i == REG_SCFG)
        scfg <= wb_dat_i[2:0];
    end
  end

  // Master engine
  wire data_end = (mst == M_DATA) & (mcnt == 7'h00)
                & ~master_wait_in_i;
  wire [23:0] cur_addr = mcmd.dbl ? {mcmd.addr[23:2], part, 1'b0}
                       : mcmd.word ? {mcmd.addr[23:1], 1'b0}
                       : mcmd.addr;
  wire [15:0] cur_wdata = part ? mdata[31:16] : mdata[15:0];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mst    <= M_IDLE;
      mcnt   <= 7'h00;
      part   <= 1'b0;
      mcmd   <= '0;
      mrdata <= 32'h0000_0000;
    end else if (ce_i) begin
      case (mst)
        M_IDLE: if (go_cmd) begin
          mcmd <= '{addr: maddr, wr: wb_dat_i[CMD_WR],
                    word: wb_dat_i[CMD_WORD] | wb_dat_i[CMD_DBL],
                    dbl: wb_dat_i[CMD_DBL]};
          part <= 1'b0;
          mst  <= M_SETUP;
          mcnt <= len_setup - 7'h01;
        end
        M_SETUP: if (mcnt == 7'h00) begin
          mst  <= M_DATA;
          mcnt <= len_data - 7'h01;
        end else mcnt <= mcnt - 7'h01;
        M_DATA: if (data_end) begin
          // Sampling at the last data cycle; data length covers access
          if (!mcmd.wr) begin
            if (!mcmd.word)
              mrdata <= {24'h00_0000, cur_addr[0] ? m_data_i[15:8]
                                                  : m_data_i[7:0]};
            else if (part) mrdata[31:16] <= m_data_i;
            else mrdata <= {16'h0000, m_data_i};
          end
          mst  <= M_HOLD;
          mcnt <= len_hold - 7'h01;
        end else if (mcnt != 7'h00) mcnt <= mcnt - 7'h01;
        M_HOLD: if (mcnt == 7'h00) begin
          mst  <= M_RECOV;
          mcnt <= len_recov - 7'h01;
        end else mcnt <= mcnt - 7'h01;
        M_RECOV: if (mcnt == 7'h00) begin
          if (mcmd.dbl && !part) begin
            part <= 1'b1;
            mst  <= M_SETUP;
            mcnt <= len_setup - 7'h01;
          end else mst <= M_IDLE;
        end else mcnt <= mcnt - 7'h01;
        default: mst <= M_IDLE;
      endcase
    end
  end

  wire in_acc = (mst == M_SETUP) | (mst == M_DATA) | (mst == M_HOLD);
  wire [15:0] lane_data = mcmd.word ? cur_wdata
                        : (cur_addr[0] ? {mdata[7:0], 8'h00}
                                       : {8'h00, mdata[7:0]});
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      m_addr_o    <= 24'h00_0000;
      m_data_o    <= 16'h0000;
      m_data_oe_o <= 1'b0;
      m_lane_n_o  <= 2'b11;
    end else if (ce_i) begin
      m_addr_o    <= in_acc ? cur_addr : 24'h00_0000;
      m_data_o    <= (in_acc & mcmd.wr) ? lane_data : 16'h0000;
      m_data_oe_o <= in_acc & mcmd.wr;
      m_lane_n_o  <= ~in_acc ? 2'b11 : mcmd.word ? 2'b00
                   : {~cur_addr[0], cur_addr[0]};
    end
  end
  assign m_cs_n_o               = ~in_acc;
  assign master_read_strobe_n_o = ~((mst == M_DATA) & ~mcmd.wr);
  assign m_write_strobe_n_o     = ~((mst == M_DATA) & mcmd.wr);

  // Slave engine
  wire s_rd  = ~s_cs_n_i & ~s_read_n_i;
  wire s_wrs = ~s_cs_n_i & ~s_write_n_i;
  logic s_we;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sst       <= S_IDLE;
      scnt      <= 4'h0;
      s_we      <= 1'b0;
      int_req_o <= '0;
      srdata    <= 16'h0000;
    end else if (ce_i) begin
      case (sst)
        S_IDLE: if (s_wrs) begin
          s_we <= 1'b1;
          scnt <= wdly(scfg[SCFG_DLY +: 2]) - 4'h1;
          sst  <= S_DLY;
        end else if (s_rd) begin
          s_we      <= 1'b0;
          int_req_o <= '{req: 1'b1, we: 1'b0, addr: s_addr_i,
                         be: ~s_lane_n_i, wdata: 16'h0000};
          sst       <= S_REQ;
        end
        S_DLY: if (!s_wrs) sst <= S_IDLE;
        else if (scnt == 4'h0) begin
          int_req_o <= '{req: 1'b1, we: 1'b1, addr: s_addr_i,
                         be: ~s_lane_n_i, wdata: s_data_i};
          sst       <= S_REQ;
        end else scnt <= scnt - 4'h1;
        S_REQ: if (int_ack_i) begin
          int_req_o.req <= 1'b0;
          srdata        <= int_rdata_i;
          sst           <= S_DONE;
        end
        // Wait for strobe release so one strobe means one access
        S_DONE: if (!s_rd && !s_wrs) sst <= S_IDLE;
        default: sst <= S_IDLE;
      endcase
    end
  end

  // Wait counter bounds the pulse even if the resource stalls longer
  wire swait_want = (sst == S_DLY) | (sst == S_REQ);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      swcnt            <= 4'h0;
      slave_wait_out_o <= 1'b0;
    end else if (ce_i) begin
      swcnt <= slave_wait_out_o ? swcnt + 4'h1 : 4'h0;
      slave_wait_out_o <= swait_want & ~(sst == S_REQ & int_ack_i)
                        & (swcnt < 4'(SWAIT_MAX_CYC - 1));
    end
  end
  assign s_data_o    = srdata;
  assign s_data_oe_o = s_rd & ~s_we & (sst == S_DONE);

  default clocking main_cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_setup_len_load: assert property (
    $rose(mst == M_SETUP) |-> mcnt == len_setup - 7'h01)
    else $error("setup phase loaded with wrong length");
  a_data_held_wait: assert property (
    (mst == M_DATA && master_wait_in_i) |=> mst == M_DATA)
    else $error("data phase left while wait active");
  a_hold_after_wait: assert property (
    (mst == M_DATA && mcnt == 7'h00 && !master_wait_in_i && ce_i)
    |=> mst == M_HOLD) else $error("hold not entered after wait release");
  a_split_second_part: assert property (
    (mst == M_RECOV && mcnt == 7'h00 && ce_i && mcmd.dbl && !part)
    |=> mst == M_SETUP && part) else $error("second half not issued");
  a_strobe_in_data: assert property (
    !master_read_strobe_n_o |-> mst == M_DATA && !m_cs_n_o)
    else $error("read strobe outside data phase");
  a_swait_max_width: assert property (
    slave_wait_out_o |-> swcnt < 4'(SWAIT_MAX_CYC))
    else $error("slave wait pulse too long");
  a_swait_start: assert property (disable iff (rst_i || !ce_i)
    (sst == S_IDLE && s_rd) |=> ##[0:2] (slave_wait_out_o || sst == S_DONE))
    else $error("slave wait not raised in time");
  a_word_even_addr: assert property (
    m_lane_n_o == 2'b00 |-> !m_addr_o[0])
    else $error("word access on odd address");
  a_read_data_out: assert property (
    sst == S_REQ && !s_we && int_ack_i && ce_i |=> s_data_o
    == $past(int_rdata_i)) else $error("read data not presented");

endmodule : aebp_port

// ===== dv/aebp_periph_model.sv
/* Peripheral on the master side of the port: a word memory with byte
   lanes and an optional wait stretch. Assumes clk_i synchronous pins. */
`timescale 1ns/1ps
module aebp_periph_model (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [23:0] addr_i,
  input  wire logic [15:0] data_i,
  input  wire logic        cs_n_i,
  input  wire logic        rd_n_i,
  input  wire logic        wr_n_i,
  input  wire logic [1:0]  lane_n_i,
  input  wire logic [7:0]  wait_len_i,
  output logic      [15:0] data_o,
  output logic             wait_o
);
  logic [15:0] mem [0:255];
  logic [15:0] last;
  logic [7:0]  wcnt;
  logic        done;
  wire  [7:0]  widx  = addr_i[8:1];
  wire         rd_on = !cs_n_i && !rd_n_i;
  wire         wr_on = !cs_n_i && !wr_n_i;
  // A released bus shows the inverse of the last word, never a stale copy
  assign data_o = rd_on ? mem[widx] : ~last;
  assign wait_o = (wcnt != 8'h00);
  always @(posedge clk_i) begin
    if (rst_i) begin
      last <= 16'h5a5a;
    end else if (rd_on) begin
      last <= mem[widx];
    end
    if (wr_on && !lane_n_i[0]) begin
      mem[widx][7:0] <= data_i[7:0];
    end
    if (wr_on && !lane_n_i[1]) begin
      mem[widx][15:8] <= data_i[15:8];
    end
  end
  // Raised one cycle into a data phase of 2 or more, once per access
  always @(posedge clk_i) begin
    if (rst_i) begin
      wcnt <= 8'h00;
      done <= 1'b0;
    end else if ((rd_on || wr_on) && !done && wait_len_i != 8'h00) begin
      wcnt <= wait_len_i;
      done <= 1'b1;
    end else if (wcnt != 8'h00) begin
      wcnt <= wcnt - 8'h01;
    end else if (cs_n_i) begin
      done <= 1'b0;
    end
  end
endmodule : aebp_periph_model

// ===== dv/aebp_port_test.sv
/* Self-checking bench of aebp_port: Wishbone register tasks, master
   transfers against the peripheral model, slave accesses by the bench.
   Assumes a 100 MHz clock and the register map of aebp_pkg. */
`timescale 1ns/1ps
module aebp_port_test
  import aebp_pkg::*;
;
  logic          clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0]    wb_adr_i, wait_len;
  logic [3:0]    wb_sel_i;
  logic [31:0]   wb_dat_i, wb_dat_o, q;
  logic [23:0]   m_addr_o;
  logic [15:0]   m_data_o, m_data_i, s_addr_i, s_data_i, s_data_o;
  logic [15:0]   int_rdata_i;
  logic [1:0]    m_lane_n_o, s_lane_n_i;
  logic          m_data_oe_o, m_cs_n_o, master_read_strobe_n_o;
  logic          m_write_strobe_n_o, master_wait_in_i, s_cs_n_i;
  logic          s_read_n_i, s_write_n_i, s_data_oe_o, slave_wait_out_o;
  logic          int_ack_i;
  aebp_ireq_type int_req_o;
  int            err_total, num_checks, cs_cnt, st_cnt, sw_run, sw_max;
  int            rcnt, rsp_dly, oe_cnt;

  aebp_port u_aebp_port (.clk_i, .rst_i, .ce_i(1'b1), .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
    .m_addr_o, .m_data_o, .m_data_oe_o, .m_data_i, .m_cs_n_o,
    .master_read_strobe_n_o, .m_write_strobe_n_o, .m_lane_n_o,
    .master_wait_in_i, .s_cs_n_i, .s_read_n_i, .s_write_n_i, .s_addr_i,
    .s_lane_n_i, .s_data_i, .s_data_o, .s_data_oe_o, .slave_wait_out_o,
    .int_req_o, .int_rdata_i, .int_ack_i);
  aebp_periph_model u_aebp_periph_model (.clk_i, .rst_i, .addr_i(m_addr_o),
    .data_i(m_data_o), .cs_n_i(m_cs_n_o), .rd_n_i(master_read_strobe_n_o),
    .wr_n_i(m_write_strobe_n_o), .lane_n_i(m_lane_n_o),
    .wait_len_i(wait_len), .data_o(m_data_i), .wait_o(master_wait_in_i));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    if (m_cs_n_o === 1'b0) cs_cnt++;
    if (master_read_strobe_n_o === 1'b0 || m_write_strobe_n_o === 1'b0)
      st_cnt++;
    sw_run = (slave_wait_out_o === 1'b1) ? sw_run + 1 : 0;
    if (sw_run > sw_max) sw_max = sw_run;
    if (m_data_oe_o === 1'b1) oe_cnt++;
    // One assignment per edge: the ack pulse is a single expression
    int_ack_i <= (int_req_o.req === 1'b1 && !int_ack_i && rcnt >= rsp_dly);
    if (int_req_o.req === 1'b1 && !int_ack_i) begin
      rcnt <= (rcnt >= rsp_dly) ? 0 : rcnt + 1;
    end
  end

  task final_report();
    if (err_total == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : final_report

  task check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (n >= 20) begin
      err_total++;
      final_report();
    end
  endtask : wb

  // Start a master transfer, poll busy, leave MRDATA in q
  task mop(input logic [3:0] cmd, input logic [23:0] a, input logic [31:0] d);
    int n;
    wb(1'b1, REG_MADDR, {8'h00, a});
    wb(1'b1, REG_MDATA, d);
    cs_cnt = 0;
    st_cnt = 0;
    oe_cnt = 0;
    wb(1'b1, REG_MCMD, {28'h000_0000, cmd});
    n = 0;
    do begin
      wb(1'b0, REG_MCMD, 32'h0000_0000);
      n++;
    end while (q[0] !== 1'b0 && n < 400);
    if (n >= 400) begin
      err_total++;
      final_report();
    end
    wb(1'b0, REG_MRDATA, 32'h0000_0000);
  endtask : mop

  // Held 120 ns, then 10 ns of recovery before the next access
  task sacc(input logic we, input logic [1:0] code, input int lim);
    logic [15:0]   d, dv;
    aebp_ireq_type rq;
    int            w, r, o, c;
    d = 16'hc0d0 | {14'h0000, code};
    c = (17 + 5 * code) / 10;
    w = 99;
    r = 99;
    o = 99;
    rq = '0;
    @(posedge clk_i);
    s_cs_n_i    <= 1'b0;
    s_lane_n_i  <= 2'b00;
    s_read_n_i  <= we;
    s_write_n_i <= !we;
    s_addr_i    <= 16'h0040 | {13'h0000, code, 1'b0};
    s_data_i    <= d;
    int_rdata_i <= d;
    for (int n = 1; n <= 12; n++) begin
      @(posedge clk_i);
      if (slave_wait_out_o === 1'b1 && w == 99) w = n;
      if (int_req_o.req === 1'b1 && r == 99) begin
        r = n;
        rq = int_req_o;
      end
      if (s_data_oe_o === 1'b1 && o == 99) begin
        o = n;
        dv = s_data_o;
      end
    end
    s_cs_n_i    <= 1'b1;
    s_read_n_i  <= 1'b1;
    s_write_n_i <= 1'b1;
    s_lane_n_i  <= 2'b11;
    @(posedge clk_i);
    check(rq.addr, 16'h0040 | {13'h0000, code, 1'b0});
    check(rq.be, 2'h3);
    if (we) begin
      check(r >= c + 1 && r <= c + 3, 1'b1);
      check(rq.wdata, d);
      check(w <= (36 + 5 * code) / 10 + 1, 1'b1);
    end else begin
      check(o <= lim + 1, 1'b1);
      check(dv, d);
      check(w <= 4, 1'b1);
    end
  endtask : sacc

  initial begin
    {err_total, num_checks, sw_run, sw_max, rcnt, rsp_dly} = '0;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wait_len} = '0;
    {s_cs_n_i, s_read_n_i, s_write_n_i, s_lane_n_i} = 5'h1f;
    {s_addr_i, s_data_i, int_rdata_i} = '0;
    wb_sel_i = 4'hf;
    rst_i = 1'b1;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, REG_PHASE, 32'h0);
    check(q, PHASE_RST);
    wb(1'b0, 8'h1c, 32'h0);
    check(q, 32'h0000_0000);
    // Three 10 ns data cycles cover strobe delay, access and setup
    wb(1'b1, REG_PHASE, 32'h0101_0301);
    mop(4'h7, 24'h00_0010, 32'h0000_beef);
    check(cs_cnt, 5);
    check(st_cnt, 3);
    check(oe_cnt, 5);
    mop(4'hb, 24'h00_0020, 32'h1234_5678);
    check(st_cnt, 6);
    check(u_aebp_periph_model.mem[8'h10], 16'h5678);
    check(u_aebp_periph_model.mem[8'h11], 16'h1234);
    mop(4'h9, 24'h00_0020, 32'h0);
    check(q, 32'h1234_5678);
    mop(4'h3, 24'h00_0031, 32'h0000_00a5);
    mop(4'h1, 24'h00_0031, 32'h0);
    check(q[7:0], 8'ha5);
    mop(4'h1, 24'h00_0020, 32'h0);
    check(q[7:0], 8'h78);
    wait_len <= 8'h0a;
    mop(4'h5, 24'h00_0010, 32'h0);
    check(st_cnt >= 11 && st_cnt <= 14, 1'b1);
    check(q[15:0], 16'hbeef);
    check(oe_cnt, 0);
    wait_len <= 8'h00;
    wb(1'b1, REG_PHASE, 32'h0101_7f01);
    mop(4'h7, 24'h00_0010, 32'h0000_1111);
    check(st_cnt, 127);
    check(cs_cnt, 129);
    sacc(1'b0, 2'h0, RD_FREE_CYC);
    wb(1'b1, REG_SCFG, 32'h0000_0004);
    rsp_dly = 5;
    sacc(1'b0, 2'h0, RD_CONT_CYC);
    rsp_dly = 0;
    for (int k = 0; k < 4; k++) begin
      wb(1'b1, REG_SCFG, k);
      sacc(1'b1, k[1:0], 0);
    end
    check(sw_max >= 1 && sw_max <= 9, 1'b1);
    final_report();
  end
endmodule : aebp_port_test
